// >>> logic/elt_regs.svh
`ifndef ELT_REGS_SVH
`define ELT_REGS_SVH
`define ELT_CLK_HZ 250000000
`define ELT_LOOPUP_TIMEOUT_S 15
`define ELT_ACK_TIME_S 3
`define ELT_BLINK_SLOW_HZ 2
`define ELT_BLINK_FAST_HZ 8
`define ELT_TICKS_PER_S (`ELT_CLK_HZ)
`define ELT_ADDR_CTRL 8'h00
`define ELT_ADDR_USER1 8'h04
`define ELT_ADDR_USER2 8'h08
`define ELT_ADDR_SLOTS 8'h0c
`define ELT_ADDR_STATUS 8'h10
`define ELT_ADDR_ERRCNT 8'h14
`define ELT_CTRL_START_BIT 0
`define ELT_CTRL_STOP_BIT 1
`define ELT_CTRL_TEST_LSB 4
`define ELT_CTRL_TEST_W 5
`define ELT_CTRL_PORT_BIT 9
`define ELT_CTRL_ALT_BIT 10
`define ELT_CTRL_DUR_LSB 12
`define ELT_CTRL_DUR_W 2
`define ELT_CTRL_ST_LSB 16
`define ELT_CTRL_ST_W 3
`define ELT_USER_LEN_LSB 24
`define ELT_USER_LEN_W 5
`define ELT_USER_MAX 24
`define ELT_ST_PASS 3'h7
`define ELT_DUR_1MIN 2'h0
`define ELT_DUR_15MIN 2'h1
`define ELT_DUR_60MIN 2'h2
`define ELT_DUR_UNLIM 2'h3
`endif

// >>> logic/elt_pkg.sv
package elt_pkg;
  typedef enum logic [4:0] {
    elt_t_self = 5'h01, elt_t_dte = 5'h02, elt_t_net = 5'h03,
    elt_t_pld = 5'h04, elt_t_lpup = 5'h05, elt_t_lpdn = 5'h06,
    elt_t_qrw = 5'h07, elt_t_p17 = 5'h08, elt_t_p324 = 5'h09,
    elt_t_p11 = 5'h0a, elt_t_ones = 5'h0b, elt_t_zeros = 5'h0c,
    elt_t_p12 = 5'h0d, elt_t_p14 = 5'h0e, elt_t_user1 = 5'h0f,
    elt_t_user2 = 5'h10, elt_t_lamp = 5'h13, elt_t_dtenet = 5'h14
  } elt_test_e;
  typedef enum logic [3:0] {
    elt_idle = 4'b0001, elt_run = 4'b0010,
    elt_pass = 4'b0100, elt_fail = 4'b1000
  } elt_state_e;
  typedef struct packed {
    logic dte_loop;
    logic line_loop;
    logic payload_loop;
    logic frac_loop;
    logic halt_payload;
    logic dte_mute;
    logic tx_pattern;
  } elt_path_s;
  typedef struct packed {
    logic test_green;
    logic test_yellow;
    logic test_red;
    logic ack;
  } elt_led_s;
endpackage : elt_pkg

// >>> logic/elt_pattern_gen.sv
`timescale 1ns/1ps
`include "elt_regs.svh"
module elt_pattern_gen (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire elt_pkg::elt_test_e test,
  input wire logic alt_code,
  input wire logic [23:0] user1,
  input wire logic [23:0] user2,
  input wire logic [4:0] user1_len,
  input wire logic [4:0] user2_len,
  output logic tx_bit
);
  logic [14:0] prbs;
  logic [4:0] phase;
  logic [4:0] period;
  logic next_bit;
  logic [4:0] ulen;

  // Loop length per pattern; user lengths of zero fall back to the maximum.
  always_comb begin
    ulen = (test == elt_pkg::elt_t_user1) ? user1_len : user2_len;
    if (ulen == 5'h00 || ulen > 5'(`ELT_USER_MAX)) begin
      ulen = 5'(`ELT_USER_MAX);
    end
    case (test)
      elt_pkg::elt_t_p11: period = 5'h02;
      elt_pkg::elt_t_p12, elt_pkg::elt_t_lpdn: period = 5'h03;
      elt_pkg::elt_t_p14, elt_pkg::elt_t_lpup: period = 5'h05;
      elt_pkg::elt_t_p17: period = 5'h08;
      elt_pkg::elt_t_p324: period = 5'h18;
      elt_pkg::elt_t_user1, elt_pkg::elt_t_user2: period = ulen;
      default: period = 5'h01;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !enable || phase + 5'h01 >= period) begin
      phase <= 5'h00;
    end else begin
      phase <= phase + 5'h01;
    end
  end

  // A 15-stage generator stands in for the word pattern; seed never zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prbs <= 15'h7fff;
    end else if (enable) begin
      prbs <= {prbs[13:0], prbs[14] ^ prbs[13]};
    end
  end

  always_comb begin
    case (test)
      elt_pkg::elt_t_qrw, elt_pkg::elt_t_dte,
      elt_pkg::elt_t_dtenet: next_bit = prbs[14];
      elt_pkg::elt_t_ones: next_bit = 1'b1;
      elt_pkg::elt_t_zeros: next_bit = 1'b0;
      elt_pkg::elt_t_p11: next_bit = (phase == 5'h00);
      elt_pkg::elt_t_p17: next_bit = (phase == 5'h00);
      elt_pkg::elt_t_p324: next_bit = (phase == 5'h00 || phase == 5'h08 ||
        phase == 5'h10);
      elt_pkg::elt_t_p12, elt_pkg::elt_t_lpdn,
      elt_pkg::elt_t_p14, elt_pkg::elt_t_lpup:
        next_bit = (phase == 5'h00) ^ alt_code;
      elt_pkg::elt_t_user1: next_bit = user1[phase];
      elt_pkg::elt_t_user2: next_bit = user2[phase];
      default: next_bit = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_bit <= 1'b1;
    end else begin
      tx_bit <= enable ? next_bit : 1'b1;
    end
  end
endmodule : elt_pattern_gen

// >>> logic/elt_pattern_chk.sv
`timescale 1ns/1ps
module elt_pattern_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic rx_bit,
  output logic [15:0] err_count,
  output logic locked
);
  logic [14:0] ref_sr;
  logic [3:0] good_run;
  logic expect_bit;

  // Self-synchronising: the reference is loaded from received bits.
  assign expect_bit = ref_sr[14] ^ ref_sr[13];

  always_ff @(posedge ref_clk) begin
    if (rst || !enable) begin
      ref_sr <= 15'h0000;
    end else begin
      ref_sr <= {ref_sr[13:0], rx_bit};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !enable) begin
      good_run <= 4'h0;
      locked <= 1'b0;
    end else if (rx_bit == expect_bit) begin
      if (good_run != 4'hf) begin
        good_run <= good_run + 4'h1;
      end else begin
        locked <= 1'b1;
      end
    end else begin
      good_run <= 4'h0;
    end
  end

  // Counter saturates rather than wrapping so a long run never reads clean.
  always_ff @(posedge ref_clk) begin
    if (rst || !enable) begin
      err_count <= 16'h0000;
    end else if (locked && rx_bit != expect_bit &&
        err_count != 16'hffff) begin
      err_count <= err_count + 16'h0001;
    end
  end
endmodule : elt_pattern_chk

// >>> logic/elt_test_ctrl.sv
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "elt_regs.svh"
module elt_test_ctrl #(
  parameter int unsigned TICKS_PER_S = `ELT_TICKS_PER_S
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic net_rx_data,
  input wire logic dte_tx_data,
  input wire logic [31:0] frac_slot_rx,
  input wire logic remote_loop_seen,
  input wire logic loopup_full_rx,
  input wire logic loopup_frac_rx,
  input wire logic loopdown_rx,
  input wire logic full_bandwidth,
  output logic net_tx_data,
  output logic net_rx_path_data,
  output elt_pkg::elt_path_s path,
  output logic [31:0] loop_slots,
  output elt_pkg::elt_led_s leds
);
  ////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl;
  logic [23:0] user1;
  logic [23:0] user2;
  logic [4:0] user1_len;
  logic [4:0] user2_len;
  logic [31:0] slots;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic start_pulse;
  logic stop_pulse;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == `ELT_ADDR_CTRL ||
          aw_addr == `ELT_ADDR_USER1 || aw_addr == `ELT_ADDR_USER2 ||
          aw_addr == `ELT_ADDR_SLOTS) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Start and stop are self-clearing; they never store in the control word.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= 32'h0000_0000;
      user1 <= 24'h333333;
      user2 <= 24'h111111;
      user1_len <= 5'(`ELT_USER_MAX);
      user2_len <= 5'(`ELT_USER_MAX);
      slots <= 32'h0000_0000;
      start_pulse <= 1'b0;
      stop_pulse <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      if (aw_held && w_held) begin
        case (aw_addr)
          `ELT_ADDR_CTRL: begin
            ctrl <= merge(ctrl, w_data, w_strb) & 32'h0007_3ff0;
            start_pulse <= w_strb[0] && w_data[`ELT_CTRL_START_BIT];
            stop_pulse <= w_strb[0] && w_data[`ELT_CTRL_STOP_BIT];
          end
          `ELT_ADDR_USER1: begin
            user1 <= w_data[23:0];
            user1_len <= w_data[`ELT_USER_LEN_LSB +: `ELT_USER_LEN_W];
          end
          `ELT_ADDR_USER2: begin
            user2 <= w_data[23:0];
            user2_len <= w_data[`ELT_USER_LEN_LSB +: `ELT_USER_LEN_W];
          end
          `ELT_ADDR_SLOTS: slots <= merge(slots, w_data, w_strb);
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  elt_pkg::elt_test_e test;
  elt_pkg::elt_state_e state;
  logic port_sel;
  logic alt_code;
  logic [1:0] dur_sel;
  logic [2:0] st_code;
  logic [2:0] st_result;
  logic [31:0] sec_div;
  logic sec_tick;
  logic [11:0] secs;
  logic [11:0] dur_limit;
  logic timed;
  logic [15:0] err_count;
  logic locked;
  logic gen_en;
  logic rloop_s1;
  logic rloop_s2;
  logic [2:0] ack_secs;
  logic ack_run;
  logic [31:0] blink_div;
  logic blink;
  logic rx_lpf_s1, rx_lpf_s2, rx_lpu_s1, rx_lpu_s2, rx_lpd_s1, rx_lpd_s2;
  logic remote_full_loop;
  logic remote_frac_loop;

  // Loop status and loop code inputs from the line side are synchronised before use.
  always_ff @(posedge ref_clk) begin
    rloop_s1 <= remote_loop_seen;
    rloop_s2 <= rloop_s1;
    rx_lpf_s1 <= loopup_full_rx;
    rx_lpf_s2 <= rx_lpf_s1;
    rx_lpu_s1 <= loopup_frac_rx;
    rx_lpu_s2 <= rx_lpu_s1;
    rx_lpd_s1 <= loopdown_rx;
    rx_lpd_s2 <= rx_lpd_s1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst || sec_tick) begin
      sec_div <= 32'h0000_0000;
    end else begin
      sec_div <= sec_div + 32'h0000_0001;
    end
  end
  assign sec_tick = (sec_div == 32'(TICKS_PER_S - 1));

  always_comb begin
    case (dur_sel)
      `ELT_DUR_1MIN: dur_limit = 12'd60;
      `ELT_DUR_15MIN: dur_limit = 12'd900;
      `ELT_DUR_60MIN: dur_limit = 12'd3600;
      default: dur_limit = 12'd0;
    endcase
  end
  assign timed = (dur_sel != `ELT_DUR_UNLIM) &&
    test != elt_pkg::elt_t_self && test != elt_pkg::elt_t_lpup &&
    test != elt_pkg::elt_t_lpdn;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= elt_pkg::elt_idle;
      test <= elt_pkg::elt_t_self;
      port_sel <= 1'b0;
      alt_code <= 1'b0;
      dur_sel <= `ELT_DUR_UNLIM;
      st_code <= `ELT_ST_PASS;
      st_result <= `ELT_ST_PASS;
      secs <= 12'h000;
    end else begin
      if (sec_tick && state == elt_pkg::elt_run) begin
        secs <= secs + 12'h001;
      end
      case (state)
        elt_pkg::elt_idle, elt_pkg::elt_pass, elt_pkg::elt_fail: begin
          if (start_pulse) begin
            test <= elt_pkg::elt_test_e'(
              ctrl[`ELT_CTRL_TEST_LSB +: `ELT_CTRL_TEST_W]);
            port_sel <= ctrl[`ELT_CTRL_PORT_BIT];
            alt_code <= ctrl[`ELT_CTRL_ALT_BIT];
            dur_sel <= ctrl[`ELT_CTRL_DUR_LSB +: `ELT_CTRL_DUR_W];
            st_code <= ctrl[`ELT_CTRL_ST_LSB +: `ELT_CTRL_ST_W];
            secs <= 12'h000;
            state <= elt_pkg::elt_run;
          end
        end
        elt_pkg::elt_run: begin
          if (stop_pulse) begin
            state <= elt_pkg::elt_idle;
          end else if (test == elt_pkg::elt_t_self && secs == 12'd1) begin
            // Code 0..5 marks a failed check; anything else passes.
            st_result <= (st_code <= 3'h5) ? st_code : `ELT_ST_PASS;
            state <= (st_code <= 3'h5) ? elt_pkg::elt_fail :
              elt_pkg::elt_pass;
          end else if ((test == elt_pkg::elt_t_lpup ||
              test == elt_pkg::elt_t_lpdn) &&
              (rloop_s2 ^ (test == elt_pkg::elt_t_lpdn))) begin
            state <= elt_pkg::elt_pass;
          end else if (test == elt_pkg::elt_t_lpup &&
              secs == 12'(`ELT_LOOPUP_TIMEOUT_S)) begin
            state <= elt_pkg::elt_fail;
          end else if (timed && secs == dur_limit) begin
            state <= elt_pkg::elt_pass;
          end
        end
        default: state <= elt_pkg::elt_idle;
      endcase
    end
  end

  // Loop codes received from the far end; both ends must share settings.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      remote_full_loop <= 1'b0;
      remote_frac_loop <= 1'b0;
    end else if (rx_lpd_s2) begin
      remote_full_loop <= 1'b0;
      remote_frac_loop <= 1'b0;
    end else if (rx_lpf_s2 && full_bandwidth) begin
      remote_full_loop <= 1'b1;
    end else if (rx_lpu_s2) begin
      remote_frac_loop <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic running;
  logic is_dte, is_net, is_pld;
  logic pat_tx;
  assign running = (state == elt_pkg::elt_run);
  assign is_dte = running && (test == elt_pkg::elt_t_dte ||
    test == elt_pkg::elt_t_dtenet);
  assign is_net = (running && full_bandwidth &&
    (test == elt_pkg::elt_t_net || test == elt_pkg::elt_t_dtenet)) ||
    remote_full_loop;
  assign is_pld = (running && test == elt_pkg::elt_t_pld) ||
    remote_frac_loop;
  assign gen_en = running && test != elt_pkg::elt_t_self &&
    test != elt_pkg::elt_t_lamp && test != elt_pkg::elt_t_net &&
    test != elt_pkg::elt_t_pld;

  elt_pattern_gen u_gen (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(gen_en),
    .test(test),
    .alt_code(alt_code),
    .user1(user1),
    .user2(user2),
    .user1_len(user1_len),
    .user2_len(user2_len),
    .tx_bit(pat_tx)
  );

  elt_pattern_chk u_chk (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(running && test == elt_pkg::elt_t_qrw),
    .rx_bit(net_rx_data),
    .err_count(err_count),
    .locked(locked)
  );

  // Frames and line coding are rebuilt by the framer downstream; here the
  // loopback paths only select which bit stream is returned.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      net_tx_data <= 1'b1;
      net_rx_path_data <= 1'b1;
      path <= '0;
      loop_slots <= 32'h0000_0000;
    end else begin
      if (is_net) begin
        net_tx_data <= net_rx_data;
      end else if (gen_en) begin
        net_tx_data <= pat_tx;
      end else if (is_pld) begin
        net_tx_data <= net_rx_data;
      end else begin
        net_tx_data <= dte_tx_data;
      end
      net_rx_path_data <= is_dte ? net_tx_data : net_rx_data;
      path.dte_loop <= is_dte;
      path.line_loop <= is_net;
      path.payload_loop <= is_pld && !port_sel;
      path.frac_loop <= is_pld && port_sel;
      path.halt_payload <= is_dte;
      path.dte_mute <= is_pld;
      path.tx_pattern <= gen_en;
      loop_slots <= (is_pld && port_sel) ? (slots & frac_slot_rx) :
        32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ack blink runs three seconds after a remote loop command succeeds.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_secs <= 3'h0;
    end else if (running && (test == elt_pkg::elt_t_lpup ||
        test == elt_pkg::elt_t_lpdn) &&
        (rloop_s2 ^ (test == elt_pkg::elt_t_lpdn))) begin
      ack_secs <= 3'(`ELT_ACK_TIME_S);
    end else if (sec_tick && ack_secs != 3'h0) begin
      ack_secs <= ack_secs - 3'h1;
    end
  end
  assign ack_run = (ack_secs != 3'h0);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      blink_div <= 32'h0000_0000;
      blink <= 1'b0;
    end else if (blink_div >= 32'(TICKS_PER_S / `ELT_BLINK_FAST_HZ / 2)) begin
      blink_div <= 32'h0000_0000;
      blink <= !blink;
    end else begin
      blink_div <= blink_div + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      leds <= '0;
    end else if (running && test == elt_pkg::elt_t_lamp) begin
      leds <= '1;
    end else begin
      leds.test_yellow <= running && (test != elt_pkg::elt_t_self ||
        blink);
      leds.test_green <= !running;
      leds.test_red <= (state == elt_pkg::elt_fail);
      leds.ack <= ack_run && blink;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `ELT_ADDR_CTRL: s_axi_rdata <= ctrl;
        `ELT_ADDR_USER1: s_axi_rdata <= {3'h0, user1_len, user1};
        `ELT_ADDR_USER2: s_axi_rdata <= {3'h0, user2_len, user2};
        `ELT_ADDR_SLOTS: s_axi_rdata <= slots;
        `ELT_ADDR_STATUS: s_axi_rdata <= {15'h0000, remote_frac_loop,
          remote_full_loop, locked, st_result, test, 2'h0, state};
        `ELT_ADDR_ERRCNT: s_axi_rdata <= {16'h0000, err_count};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : elt_test_ctrl

// >>> sim/elt_sva.sv
`timescale 1ns/1ps
module elt_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire elt_pkg::elt_path_s path
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A second write must wait until the response has been taken.
  property p_bref; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_bref: assert property (p_bref) else $error("aw open in resp");
  property p_bend; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bend: assert property (p_bend) else $error("bvalid stuck");
  property p_arref; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arref: assert property (p_arref) else $error("ar open in resp");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rend; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rend: assert property (p_rend) else $error("rvalid stuck");
  property p_pat; path.dte_loop |-> path.tx_pattern; endproperty
  a_pat: assert property (p_pat) else $error("pattern off in loop");
  property p_halt; path.dte_loop |-> path.halt_payload; endproperty
  a_halt: assert property (p_halt) else $error("payload not halted");
  property p_mute; path.payload_loop |-> path.dte_mute; endproperty
  a_mute: assert property (p_mute) else $error("dte not muted");
endmodule : elt_sva
bind elt_test_ctrl elt_sva sva_u (.ref_clk, .rst, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .path);

// >>> sim/elt_remote.sv
`timescale 1ns/1ps
module elt_remote (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic loop_en,
  input wire logic net_tx_data,
  output logic net_rx_data,
  output logic remote_loop_seen
);
  // When not looped the far end toggles, so no stale copy passes as data.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      net_rx_data <= 1'b0;
      remote_loop_seen <= 1'b0;
    end else begin
      remote_loop_seen <= loop_en;
      net_rx_data <= loop_en ? net_tx_data : ~net_rx_data;
    end
  end
endmodule : elt_remote

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic rmt_loop = 1'b0;
  logic lpf = 1'b0, lpd = 1'b0;
  logic rxp;
  logic [31:0] fsl = 32'h0000_00f0, ls;
  logic fb = 1'b1;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [1:0] br, rr, rs;
  logic awr, wrdy, bv, arr, rv, ntx, nrx, seen;
  logic [23:0] v;
  elt_pkg::elt_path_s path;
  elt_pkg::elt_led_s leds;
  int n_fail = 0, compares = 0, cyc = 0, n, a;
  logic [4:0] pt [9] = '{5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h0e, 5'h0f, 5'h08,
    5'h09, 5'h0d};
  logic [31:0] pa [9] = '{0, 0, 0, 0, 32'h400, 0, 0, 0, 0};
  int pe [9] = '{5, 10, 0, 2, 8, 2, 1, 3, 1};
  int pw [9] = '{10, 10, 10, 10, 10, 10, 8, 24, 3};
  logic [4:0] tl [4] = '{5'h02, 5'h04, 5'h14, 5'h04};
  logic [6:0] pm [4] = '{7'h45, 7'h12, 7'h60, 7'h0a};
  logic [31:0] ta [4] = '{0, 0, 0, 32'h200};
  elt_test_ctrl #(.TICKS_PER_S(20)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .net_rx_data(nrx),
    .dte_tx_data(cyc[0]), .frac_slot_rx(fsl), .remote_loop_seen(seen),
    .loopup_full_rx(lpf), .loopup_frac_rx(1'b0), .loopdown_rx(lpd),
    .full_bandwidth(fb), .net_tx_data(ntx), .net_rx_path_data(rxp),
    .path(path), .loop_slots(ls), .leds(leds));
  elt_remote far_u (.ref_clk(ref_clk), .rst(rst), .loop_en(rmt_loop),
    .net_tx_data(ntx), .net_rx_data(nrx), .remote_loop_seen(seen));
  initial forever #2 ref_clk = ~ref_clk;
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // The hang limit covers the slowest case, a loopup that never answers.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Ready is never lowered; back-to-back calls each drive it high again.
  task automatic wr(input logic [7:0] ad, input logic [31:0] x);
    aw <= ad;
    wd <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    ar <= ad;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge ref_clk); while (!arr);
    arv <= 1'b0;
    do @(posedge ref_clk); while (!rv);
    d = rdat;
    rs = rr;
  endtask : rd
  task automatic go(input logic [4:0] t, input logic [31:0] x);
    wr(8'h00, x | 32'h3001 | {23'h0, t, 4'h0});
  endtask : go
  task automatic done;
    do rd(8'h10); while (d[3:0] == 4'h2);
  endtask : done
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(8'h10);
    chk("idle", 32'h1, {28'h0, d[3:0]});
    rd(8'h24);
    chk("rresp", 32'h2, {30'h0, rs});
    for (int c = 0; c < 7; c++) begin
      go(5'h01, c << 16);
      done();
      chk("st_code", (c < 6) ? c : 7, {29'h0, d[13:11]});
      chk("st_state", (c < 6) ? 8 : 4, {28'h0, d[3:0]});
    end
    go(5'h13, 0);
    repeat (3) @(posedge ref_clk);
    chk("lamp", 32'hf, {28'h0, leds});
    wr(8'h00, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk("lamp_end", 32'h8, {28'h0, leds});
    wr(8'h0c, 32'h0000_0ff0);
    for (int i = 0; i < 4; i++) begin
      go(tl[i], ta[i]);
      repeat (3) @(posedge ref_clk);
      chk("path", {25'h0, pm[i]}, {25'h0, path & pm[i]});
      chk("slots", (i == 3) ? 32'hf0 : 32'h0, ls);
      if (i != 1 && i != 3) begin
        repeat (8) begin
          d[0] = ntx;
          @(posedge ref_clk);
          chk("dte_rx", {31'h0, d[0]}, {31'h0, rxp});
        end
      end
      wr(8'h00, 32'h2);
    end
    wr(8'h04, 32'h05000001);
    for (int i = 0; i < 9; i++) begin
      go(pt[i], pa[i]);
      repeat (4) @(posedge ref_clk);
      v = '0;
      for (int b = 0; b < pw[i]; b++) begin
        @(posedge ref_clk);
        v[b] = ntx;
      end
      wr(8'h00, 32'h2);
      chk("ones", pe[i], $countones(v));
      if (i == 0) chk("alt", 9, $countones((v ^ (v >> 1)) & 24'h1ff));
    end
    // Looped far end must give a clean count; a toggling one must not.
    rmt_loop <= 1'b1;
    go(5'h07, 0);
    repeat (60) @(posedge ref_clk);
    rd(8'h14);
    a = d;
    rd(8'h10);
    chk("qrw_lock", 1, d[14]);
    repeat (40) @(posedge ref_clk);
    rd(8'h14);
    chk("qrw_err", a, d);
    rmt_loop <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rd(8'h14);
    chk("qrw_hit", 1, d > a);
    wr(8'h00, 32'h2);
    rmt_loop <= 1'b1;
    go(5'h05, 0);
    done();
    chk("loopup", 32'h4, {28'h0, d[3:0]});
    a = 0;
    repeat (40) begin
      @(posedge ref_clk);
      a += leds.ack;
    end
    chk("ack", 1, a > 0);
    rmt_loop <= 1'b0;
    repeat (4) @(posedge ref_clk);
    n = cyc;
    go(5'h05, 0);
    done();
    n = cyc - n;
    chk("lpup_fail", 32'h8, {28'h0, d[3:0]});
    chk("lpup_time", 1, n >= 280 && n <= 340);
    lpf <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(8'h10);
    chk("rfull", 1, d[15]);
    chk("rline", 1, path.line_loop);
    lpf <= 1'b0;
    lpd <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(8'h10);
    chk("rdown", 0, d[15]);
    lpd <= 1'b0;
    report_and_stop();
  end
endmodule : testbench
